//--- core/spsa_defs.svh
// constants for the sync/async serial port: offsets, fields, resets, counts
//------------------------------------------------------------------
// How it works
// - sync transmit: done flag at next first phase
// - sync receive starts only if enabled, flag clear
// - sync receive: drive shift clock, sample at next first phase
// - eight bits, then receive flag next first phase
// - receive flag set blocks further receptions
// - async frame: start 0, eight bits lsb first, stop 1
// - received stop bit lands in ninth-bit field
// - bit rate is overflow rate over 16 or 32
// - buffer write; first bit after next rollover
// - each later bit after each later rollover
// - stop bit and transmit flag both at tenth rollover
//------------------------------------------------------------------
`ifndef SPSA_DEFS_SVH
`define SPSA_DEFS_SVH

// register offsets
`define SPSA_OFS_CTRL 8'h00
`define SPSA_OFS_BUF 8'h04
`define SPSA_OFS_RELOAD 8'h08
`define SPSA_OFS_STAT 8'h0C
`define SPSA_OFS_MASK 8'h10

// field positions and reset values
`define SPSA_ST_TX 0
`define SPSA_ST_RX 1
`define SPSA_CTRL_RST 3'h0
`define SPSA_RELOAD_RST 8'h00
`define SPSA_MASK_RST 2'h0

// machine cycle phases, one clock each, four per machine cycle
`define SPSA_PH_C1 2'h0
`define SPSA_PH_C3 2'h2
`define SPSA_PH_C4 2'h3

// bit and tick counts
`define SPSA_TMR_TOP 8'hFF
`define SPSA_DIV_TOP 4'hF
`define SPSA_MID_TICK 4'h7
`define SPSA_END_TICK 4'hF
`define SPSA_LAST_SYNC 4'h8
`define SPSA_LAST_ASYNC 4'h9
`define SPSA_DATA_LAST 4'h7

`endif

//--- core/spsa_pkg.sv
// types shared by the serial port files
package spsa_pkg;

  // software controls, packed in register order
  typedef struct packed {
    logic slow_baud;
    logic rx_en;
    logic async_mode;
  } spsa_ctrl_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SYNC = 3'b010,
    TX_ASYNC = 3'b100
  } spsa_tx_st_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_SYNC = 5'b00010,
    RX_START = 5'b00100,
    RX_DATA = 5'b01000,
    RX_STOP = 5'b10000
  } spsa_rx_st_t;

endpackage

//--- core/spsa_baud.sv
// reload timer and divide-by-16 counter for the async bit rate
`include "spsa_defs.svh"

module spsa_baud (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic mc_tick,
  input wire logic [7:0] reload,
  input wire logic slow,
  // rate pulses
  output logic samp,
  output logic roll
);

  logic [7:0] timer_ff;
  logic half_ff;
  logic [3:0] div_ff;
  logic samp_ff;
  logic roll_ff;
  logic ovf;

  assign ovf = mc_tick && (timer_ff == `SPSA_TMR_TOP);
  assign samp = samp_ff;
  assign roll = roll_ff;

  // timer counts machine cycles and reloads on overflow
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      timer_ff <= `SPSA_RELOAD_RST;
    else if (ovf)
      timer_ff <= reload;
    else if (mc_tick)
      timer_ff <= timer_ff + 8'h01;
  end

  // extra halving for the slow rate
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      half_ff <= 1'b0;
    else if (ovf)
      half_ff <= !half_ff;
  end

  // sixteen sample pulses make one bit time
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      samp_ff <= 1'b0;
    else
      samp_ff <= ovf && (!slow || half_ff);
  end

  // divide-by-16 counter, rollover pulse paces transmit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_ff <= 4'h0;
      roll_ff <= 1'b0;
    end
    else
    begin
      roll_ff <= samp_ff && (div_ff == `SPSA_DIV_TOP);
      if (samp_ff)
        div_ff <= div_ff + 4'h1;
    end
  end

  property p_samp_fast;
    @(posedge clk) disable iff (!rst_n) (ovf && !slow) |=> samp_ff;
  endproperty
  a_samp_fast: assert property (p_samp_fast) else $error("fast rate missed a sample");

  property p_samp_slow;
    @(posedge clk) disable iff (!rst_n) (ovf && slow && !half_ff) |=> !samp_ff;
  endproperty
  a_samp_slow: assert property (p_samp_slow) else $error("slow rate sampled too often");

  property p_roll;
    @(posedge clk) disable iff (!rst_n) roll_ff |-> ($past(div_ff) == `SPSA_DIV_TOP);
  endproperty
  a_roll: assert property (p_roll) else $error("rollover at wrong count");

endmodule

//--- core/spsa_top.sv
// serial port: synchronous shift mode and 10-bit asynchronous mode
//
// Local design decisions: the placing of the registers and the plain strobed port.
`include "spsa_defs.svh"

module spsa_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // serial pins
  output logic txd,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  // interrupt
  output logic irq
);

  //------------------------------------------------------------------
  // state
  //------------------------------------------------------------------
  logic [1:0] phase_ff;
  spsa_pkg::spsa_ctrl_t ctrl_ff;
  logic ninth_ff;
  logic [7:0] reload_ff;
  logic [7:0] rx_buf_ff;
  logic [1:0] stat_ff;
  logic [1:0] mask_ff;
  logic roll_pend_ff;
  logic [2:0] rxd_sync_ff;
  logic rxd_lvl_ff;
  logic rxd_prev_ff;
  spsa_pkg::spsa_tx_st_t tx_st_ff;
  logic [9:0] tx_sh_ff;
  logic [3:0] tx_cnt_ff;
  spsa_pkg::spsa_rx_st_t rx_st_ff;
  logic [7:0] rx_sh_ff;
  logic [3:0] rx_cnt_ff;
  logic [3:0] rx_tick_ff;
  logic txd_ff;
  logic rxd_out_ff;
  logic rxd_oe_ff;
  logic irq_ff;
  logic [7:0] rdata_ff;
  logic samp;
  logic roll;

  function automatic logic hit(input logic strobe, input logic [7:0] a,
                               input logic [7:0] ofs);
    return strobe && (a == ofs);
  endfunction

  //------------------------------------------------------------------
  // decode and events
  //------------------------------------------------------------------
  logic c1, c3, c4;
  logic wr_buf, tx_idle, rx_idle, shift_busy, shift_last;
  logic tx_fire, tx_done_set, rx_sync_start, rx_sync_done, rx_stop_take;
  logic rx_store, rx_done_set;
  logic rxd_nxt;

  assign c1 = (phase_ff == `SPSA_PH_C1);
  assign c3 = (phase_ff == `SPSA_PH_C3);
  assign c4 = (phase_ff == `SPSA_PH_C4);
  assign wr_buf = hit(wr, addr, `SPSA_OFS_BUF);
  assign tx_idle = (tx_st_ff == spsa_pkg::TX_IDLE);
  assign rx_idle = (rx_st_ff == spsa_pkg::RX_IDLE);
  assign shift_busy = (tx_st_ff == spsa_pkg::TX_SYNC) || (rx_st_ff == spsa_pkg::RX_SYNC);
  assign shift_last = (tx_st_ff == spsa_pkg::TX_SYNC) ? (tx_cnt_ff == `SPSA_LAST_SYNC)
                                                      : (rx_cnt_ff == `SPSA_LAST_SYNC);
  assign tx_fire = c1 && roll_pend_ff && (tx_st_ff == spsa_pkg::TX_ASYNC);
  assign tx_done_set = ((tx_st_ff == spsa_pkg::TX_SYNC) && c1 && shift_last)
                    || (tx_fire && (tx_cnt_ff == `SPSA_LAST_ASYNC));
  assign rx_sync_start = c4 && rx_idle && tx_idle && !ctrl_ff.async_mode
                      && ctrl_ff.rx_en && !stat_ff[`SPSA_ST_RX];
  assign rx_sync_done = (rx_st_ff == spsa_pkg::RX_SYNC) && c1 && shift_last;
  assign rx_stop_take = (rx_st_ff == spsa_pkg::RX_STOP) && samp
                     && (rx_tick_ff == `SPSA_END_TICK);
  // a frame that ends while the flag is still up is dropped
  assign rx_store = rx_stop_take && !stat_ff[`SPSA_ST_RX];
  assign rx_done_set = rx_sync_done || rx_store;
  // level the filter shows after this edge; sync rx reads it at the first phase
  assign rxd_nxt = (rxd_sync_ff[1] == rxd_sync_ff[2]) ? rxd_sync_ff[2] : rxd_lvl_ff;

  spsa_baud u_baud (
    .clk(clk),
    .rst_n(rst_n),
    .mc_tick(c4),
    .reload(reload_ff),
    .slow(ctrl_ff.slow_baud),
    .samp(samp),
    .roll(roll)
  );

  // machine cycle phase counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      phase_ff <= `SPSA_PH_C1;
    else
      phase_ff <= phase_ff + 2'h1;
  end

  // rollover waits for the next first phase; a new one wins over the consume
  // a rollover seen before the buffer write must not start the frame early
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      roll_pend_ff <= 1'b0;
    else
      roll_pend_ff <= (roll || (roll_pend_ff && !c1)) && !(wr_buf && tx_idle);
  end

  // input filter: level moves only when second and third stages agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxd_sync_ff <= 3'h7;
      rxd_lvl_ff <= 1'b1;
      rxd_prev_ff <= 1'b1;
    end
    else
    begin
      rxd_sync_ff <= {rxd_sync_ff[1:0], rxd_in};
      if (rxd_sync_ff[1] == rxd_sync_ff[2])
        rxd_lvl_ff <= rxd_sync_ff[2];
      rxd_prev_ff <= rxd_lvl_ff;
    end
  end

  //------------------------------------------------------------------
  // registers
  //------------------------------------------------------------------
  // control, reload and mask writes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff <= `SPSA_CTRL_RST;
      reload_ff <= `SPSA_RELOAD_RST;
      mask_ff <= `SPSA_MASK_RST;
    end
    else if (hit(wr, addr, `SPSA_OFS_CTRL))
      ctrl_ff <= wdata[2:0];
    else if (hit(wr, addr, `SPSA_OFS_RELOAD))
      reload_ff <= wdata;
    else if (hit(wr, addr, `SPSA_OFS_MASK))
      mask_ff <= wdata[1:0];
  end

  // done flags: hardware sets, software clears by writing one, set wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stat_ff <= 2'h0;
    else
    begin
      if (tx_done_set)
        stat_ff[`SPSA_ST_TX] <= 1'b1;
      else if (hit(wr, addr, `SPSA_OFS_STAT) && wdata[`SPSA_ST_TX])
        stat_ff[`SPSA_ST_TX] <= 1'b0;
      if (rx_done_set)
        stat_ff[`SPSA_ST_RX] <= 1'b1;
      else if (hit(wr, addr, `SPSA_OFS_STAT) && wdata[`SPSA_ST_RX])
        stat_ff[`SPSA_ST_RX] <= 1'b0;
    end
  end

  // received byte and stop bit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_buf_ff <= 8'h00;
      ninth_ff <= 1'b0;
    end
    else if (rx_sync_done)
      rx_buf_ff <= {rxd_nxt, rx_sh_ff[7:1]};
    else if (rx_store)
    begin
      rx_buf_ff <= rx_sh_ff;
      ninth_ff <= rxd_lvl_ff;
    end
  end

  // read data stands one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= 8'h00;
    else if (hit(rd, addr, `SPSA_OFS_CTRL))
      rdata_ff <= {4'h0, ninth_ff, ctrl_ff};
    else if (hit(rd, addr, `SPSA_OFS_BUF))
      rdata_ff <= rx_buf_ff;
    else if (hit(rd, addr, `SPSA_OFS_RELOAD))
      rdata_ff <= reload_ff;
    else if (hit(rd, addr, `SPSA_OFS_STAT))
      rdata_ff <= {6'h00, stat_ff};
    else if (hit(rd, addr, `SPSA_OFS_MASK))
      rdata_ff <= {6'h00, mask_ff};
    else
      rdata_ff <= 8'h00;
  end

  // level interrupt, one cycle behind the flags
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(stat_ff & mask_ff);
  end

  //------------------------------------------------------------------
  // transmit
  //------------------------------------------------------------------
  // writes while busy are ignored; no queue behind the buffer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_st_ff <= spsa_pkg::TX_IDLE;
      tx_sh_ff <= 10'h3FF;
      tx_cnt_ff <= 4'h0;
    end
    else
      case (tx_st_ff)
        spsa_pkg::TX_IDLE:
          if (wr_buf && ctrl_ff.async_mode)
          begin
            tx_sh_ff <= {1'b1, wdata, 1'b0};
            tx_cnt_ff <= 4'h0;
            tx_st_ff <= spsa_pkg::TX_ASYNC;
          end
          else if (wr_buf && rx_idle)
          begin
            tx_sh_ff <= {2'h3, wdata};
            tx_cnt_ff <= 4'h0;
            tx_st_ff <= spsa_pkg::TX_SYNC;
          end
        spsa_pkg::TX_SYNC:
          if (c1 && shift_last)
            tx_st_ff <= spsa_pkg::TX_IDLE;
          else if (c1)
          begin
            tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
            tx_cnt_ff <= tx_cnt_ff + 4'h1;
          end
        spsa_pkg::TX_ASYNC:
          if (tx_fire)
          begin
            tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
            tx_cnt_ff <= tx_cnt_ff + 4'h1;
            if (tx_cnt_ff == `SPSA_LAST_ASYNC)
              tx_st_ff <= spsa_pkg::TX_IDLE;
          end
        default:
          tx_st_ff <= spsa_pkg::TX_IDLE;
      endcase
  end

  // txd: shift clock in sync mode, frame bits in async mode; idles high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      txd_ff <= 1'b1;
    else if (shift_busy && c1 && !shift_last)
      txd_ff <= 1'b0;
    else if (shift_busy && c3)
      txd_ff <= 1'b1;
    else if (tx_fire)
      txd_ff <= tx_sh_ff[0];
  end

  // sync transmit data goes out on the data pin, driven only while shifting
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxd_out_ff <= 1'b1;
      rxd_oe_ff <= 1'b0;
    end
    else if ((tx_st_ff == spsa_pkg::TX_SYNC) && c1)
    begin
      rxd_out_ff <= shift_last ? 1'b1 : tx_sh_ff[0];
      rxd_oe_ff <= !shift_last;
    end
  end

  //------------------------------------------------------------------
  // receive
  //------------------------------------------------------------------
  // sync samples at the next first phase: the filter lags a whole machine cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_st_ff <= spsa_pkg::RX_IDLE;
      rx_sh_ff <= 8'h00;
      rx_cnt_ff <= 4'h0;
      rx_tick_ff <= 4'h0;
    end
    else
      case (rx_st_ff)
        spsa_pkg::RX_IDLE:
        begin
          rx_cnt_ff <= 4'h0;
          rx_tick_ff <= 4'h0;
          if (rx_sync_start)
            rx_st_ff <= spsa_pkg::RX_SYNC;
          else if (ctrl_ff.async_mode && ctrl_ff.rx_en && rxd_prev_ff && !rxd_lvl_ff)
            rx_st_ff <= spsa_pkg::RX_START;
        end
        spsa_pkg::RX_SYNC:
          if (c1)
          begin
            // bit of the period that just ended, as the filter now shows it
            if (rx_cnt_ff != 4'h0)
              rx_sh_ff <= {rxd_nxt, rx_sh_ff[7:1]};
            if (shift_last)
              rx_st_ff <= spsa_pkg::RX_IDLE;
            else
              rx_cnt_ff <= rx_cnt_ff + 4'h1;
          end
        spsa_pkg::RX_START:
          if (samp && (rx_tick_ff == `SPSA_MID_TICK))
          begin
            rx_tick_ff <= 4'h0;
            rx_st_ff <= rxd_lvl_ff ? spsa_pkg::RX_IDLE : spsa_pkg::RX_DATA;
          end
          else if (samp)
            rx_tick_ff <= rx_tick_ff + 4'h1;
        spsa_pkg::RX_DATA:
          if (samp)
          begin
            rx_tick_ff <= rx_tick_ff + 4'h1;
            if (rx_tick_ff == `SPSA_END_TICK)
            begin
              rx_sh_ff <= {rxd_lvl_ff, rx_sh_ff[7:1]};
              rx_cnt_ff <= rx_cnt_ff + 4'h1;
              if (rx_cnt_ff == `SPSA_DATA_LAST)
                rx_st_ff <= spsa_pkg::RX_STOP;
            end
          end
        spsa_pkg::RX_STOP:
          if (rx_stop_take)
            rx_st_ff <= spsa_pkg::RX_IDLE;
          else if (samp)
            rx_tick_ff <= rx_tick_ff + 4'h1;
        default:
          rx_st_ff <= spsa_pkg::RX_IDLE;
      endcase
  end

  assign rdata = rdata_ff;
  assign txd = txd_ff;
  assign rxd_out = rxd_out_ff;
  assign rxd_oe = rxd_oe_ff;
  assign irq = irq_ff;

  //------------------------------------------------------------------
  // assertions
  //------------------------------------------------------------------
  sequence s_sync_tx_last;
    (tx_st_ff == spsa_pkg::TX_SYNC) && c1 && (tx_cnt_ff == `SPSA_LAST_SYNC);
  endsequence
  property p_sync_tx_done;
    @(posedge clk) disable iff (!rst_n)
      s_sync_tx_last |=> stat_ff[`SPSA_ST_TX] && !rxd_oe_ff && txd_ff;
  endproperty
  a_sync_tx_done: assert property (p_sync_tx_done) else $error("sync tx flag not set");

  property p_rx_gate;
    @(posedge clk) disable iff (!rst_n)
      $rose(rx_st_ff == spsa_pkg::RX_SYNC) |->
        $past(ctrl_ff.rx_en) && !$past(stat_ff[`SPSA_ST_RX]) && !$past(ctrl_ff.async_mode);
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("sync rx started when barred");

  sequence s_clk_rise;
    (rx_st_ff == spsa_pkg::RX_SYNC) && c1 && !shift_last ##1 !txd_ff ##1 !txd_ff;
  endsequence
  property p_shift_clock;
    @(posedge clk) disable iff (!rst_n) s_clk_rise |=> txd_ff [*2];
  endproperty
  a_shift_clock: assert property (p_shift_clock) else $error("shift clock shape wrong");

  property p_rx_done;
    @(posedge clk) disable iff (!rst_n)
      rx_sync_done |=> stat_ff[`SPSA_ST_RX] && (rx_buf_ff == rx_sh_ff)
                       && ($past(rx_cnt_ff) == 4'h8);
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("sync rx flag or byte wrong");

  property p_rx_hold;
    @(posedge clk) disable iff (!rst_n)
      (stat_ff[`SPSA_ST_RX] && rx_idle && !ctrl_ff.async_mode) |=> rx_idle;
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx restarted with flag set");

  property p_start_bit;
    @(posedge clk) disable iff (!rst_n)
      (tx_fire && (tx_cnt_ff == 4'h0)) |=> !txd_ff ##1 !txd_ff;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit not low");

  property p_ninth;
    @(posedge clk) disable iff (!rst_n) rx_store |=> (ninth_ff == $past(rxd_lvl_ff));
  endproperty
  a_ninth: assert property (p_ninth) else $error("stop bit not stored");

  property p_tx_paced;
    @(posedge clk) disable iff (!rst_n)
      ((tx_st_ff == spsa_pkg::TX_ASYNC) && !tx_fire) |=> $stable(txd_ff);
  endproperty
  a_tx_paced: assert property (p_tx_paced) else $error("tx bit moved off rollover");

  property p_tx_done;
    @(posedge clk) disable iff (!rst_n)
      (tx_fire && (tx_cnt_ff == `SPSA_LAST_ASYNC)) |=> stat_ff[`SPSA_ST_TX] && txd_ff && tx_idle;
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("tx flag not set at stop");

  property p_false_start;
    @(posedge clk) disable iff (!rst_n)
      ((rx_st_ff == spsa_pkg::RX_START) && samp && (rx_tick_ff == `SPSA_MID_TICK) && rxd_lvl_ff)
        |=> rx_idle;
  endproperty
  a_false_start: assert property (p_false_start) else $error("glitch taken as start");

endmodule

//--- dv/spsa_partner.sv
// far-side serial device model: shift register in sync mode, uart in async mode
module spsa_partner (
  // clock
  input wire logic clk,
  // serial pins as seen from the far side
  input wire logic txd,
  input wire logic rxd_line,
  input wire logic rxd_oe,
  output logic drv
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] sync_byte_ff;
  logic [7:0] cap_ff;
  logic sync_on_ff;
  int sync_idx_ff;
  int falls_ff;

  //--------------------------------------------------------------
  // sync mode
  //--------------------------------------------------------------
  // idle line is high so a released pin never looks like a start bit
  initial
  begin
    drv = 1'b1;
    sync_on_ff = 1'b0;
    sync_idx_ff = 0;
    falls_ff = 0;
    cap_ff = 8'h00;
  end

  // new bit on each falling shift clock; after the byte the line keeps toggling
  always @(negedge txd)
  begin
    falls_ff++;
    if (sync_on_ff)
    begin
      if (sync_idx_ff < 8)
        drv = sync_byte_ff[sync_idx_ff];
      else
        drv = ~drv;
      sync_idx_ff++;
    end
  end

  // capture device-driven data on the rising shift clock
  always @(posedge txd)
  begin
    if (rxd_oe === 1'b1)
      cap_ff = {rxd_line, cap_ff[7:1]};
  end

  task load_sync(input logic [7:0] b);
    sync_byte_ff = b;
    sync_idx_ff = 0;
    falls_ff = 0;
    sync_on_ff = 1'b1;
  endtask

  task stop_sync();
    sync_on_ff = 1'b0;
    drv = 1'b1;
  endtask

  //--------------------------------------------------------------
  // async mode
  //--------------------------------------------------------------
  // start 0, data lsb first, then the given stop level, one bit time each
  task automatic send_frame(input logic [7:0] b, input logic stop, input int bt);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    @(posedge clk);
    for (int i = 0; i < 10; i++)
    begin
      drv <= f[i];
      repeat (bt) @(posedge clk);
    end
    drv <= 1'b1;
  endtask

  // wait for a start bit, measure its width, sample each bit mid-way
  task automatic get_frame(input int bt, output logic [7:0] b, output logic stop,
                           output int width, output logic ok);
    int n;
    n = 0;
    width = 0;
    b = 8'h00;
    stop = 1'b0;
    while (txd !== 1'b0 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    ok = (n < 4000);
    for (int c = 0; c < bt * 10; c++)
    begin
      @(posedge clk);
      if (width == 0 && txd === 1'b1)
        width = c + 1;
      if (c % bt == bt / 2 && c / bt >= 1)
      begin
        if (c / bt <= 8)
          b[c / bt - 1] = txd;
        else
          stop = txd;
      end
    end
  endtask
endmodule

//--- dv/testbench.sv
// self-checking bench for the serial port through its register port
`include "spsa_defs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk;
  logic rst_n;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic txd;
  logic rxd_out;
  logic rxd_oe;
  logic irq;
  logic drv;
  wire logic rxd_line;
  logic [7:0] rv;
  logic [7:0] fb;
  logic fs;
  logic fok;
  int fw;
  int errors;
  int cmp_count;
  int cyc;

  // data pin: the device wins while it drives, else the far side
  assign rxd_line = rxd_oe ? rxd_out : drv;

  spsa_top dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .txd(txd), .rxd_in(rxd_line), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .irq(irq)
  );

  spsa_partner partner (
    .clk(clk), .txd(txd), .rxd_line(rxd_line), .rxd_oe(rxd_oe), .drv(drv)
  );

  //--------------------------------------------------------------
  // clock, timeout and reporting
  //--------------------------------------------------------------
  initial clk = 1'b0;
  always #50 clk = ~clk;

  // whole run needs well under 10000 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      $display("wrong value run length expected finish seen hang");
      final_report();
    end
  end

  task final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  //--------------------------------------------------------------
  // register port tasks
  //--------------------------------------------------------------
  task reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task reg_rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask

  // bounded poll of one status flag
  task wait_flag(input int b);
    int n;
    n = 0;
    reg_rd(`SPSA_OFS_STAT);
    while (rv[b] !== 1'b1 && n < 600)
    begin
      reg_rd(`SPSA_OFS_STAT);
      n++;
    end
  endtask

  //--------------------------------------------------------------
  // main sequence
  //--------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    errors = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check("txd idle", txd, 1'b1);
    check("pin enable idle", rxd_oe, 1'b0);
    check("irq idle", irq, 1'b0);
    // reset values, and an unmapped place reads zero even after a write
    reg_wr(8'h20, 8'hFF);
    reg_rd(`SPSA_OFS_CTRL);
    check("ctrl reset", rv, 8'h00);
    reg_rd(`SPSA_OFS_RELOAD);
    check("reload reset", rv, 8'h00);
    reg_rd(`SPSA_OFS_STAT);
    check("stat reset", rv, 8'h00);
    reg_rd(`SPSA_OFS_MASK);
    check("mask reset", rv, 8'h00);
    reg_rd(8'h20);
    check("unmapped read", rv, 8'h00);
    // no shift clock while reception is disabled
    repeat (40) @(posedge clk);
    check("shift clocks while disabled", partner.falls_ff, 0);

    // sync receive, then blocked while the flag stands
    partner.load_sync(8'h96);
    reg_wr(`SPSA_OFS_CTRL, 8'h02);
    wait_flag(`SPSA_ST_RX);
    check("sync rx flag", rv[`SPSA_ST_RX], 1'b1);
    check("sync shift clocks", partner.falls_ff, 8);
    reg_rd(`SPSA_OFS_BUF);
    check("sync rx byte", rv, 8'h96);
    repeat (64) @(posedge clk);
    check("shift clocks while flag set", partner.falls_ff, 8);
    partner.load_sync(8'h3B);
    reg_wr(`SPSA_OFS_STAT, 8'h02);
    wait_flag(`SPSA_ST_RX);
    reg_rd(`SPSA_OFS_BUF);
    check("sync rx after clear", rv, 8'h3B);
    reg_wr(`SPSA_OFS_CTRL, 8'h00);
    reg_wr(`SPSA_OFS_STAT, 8'h02);
    partner.stop_sync();

    // sync transmit
    reg_wr(`SPSA_OFS_BUF, 8'hC3);
    wait_flag(`SPSA_ST_TX);
    check("sync tx flag", rv[`SPSA_ST_TX], 1'b1);
    check("sync tx byte", partner.cap_ff, 8'hC3);
    check("pin released", rxd_oe, 1'b0);
    reg_wr(`SPSA_OFS_STAT, 8'h01);

    // async transmit at both rate dividers; bit 0 of A5 is 1 so start width shows
    reg_wr(`SPSA_OFS_RELOAD, 8'hFF);
    reg_rd(`SPSA_OFS_RELOAD);
    check("reload readback", rv, 8'hFF);
    for (int s = 0; s < 2; s++)
    begin
      reg_wr(`SPSA_OFS_CTRL, {5'h00, s[0], 2'b01});
      reg_wr(`SPSA_OFS_BUF, 8'hA5);
      partner.get_frame(64 << s, fb, fs, fw, fok);
      check("start seen", fok, 1'b1);
      check("async tx byte", fb, 8'hA5);
      check("async stop", fs, 1'b1);
      check("bit width", fw, 64 << s);
      reg_rd(`SPSA_OFS_STAT);
      check("async tx flag", rv[`SPSA_ST_TX], 1'b1);
      reg_wr(`SPSA_OFS_STAT, 8'h01);
    end

    // async receive with interrupt, then stop level 0 and overrun
    reg_wr(`SPSA_OFS_CTRL, 8'h03);
    reg_wr(`SPSA_OFS_MASK, 8'h02);
    partner.send_frame(8'h3C, 1'b1, 64);
    wait_flag(`SPSA_ST_RX);
    reg_rd(`SPSA_OFS_BUF);
    check("async rx byte", rv, 8'h3C);
    reg_rd(`SPSA_OFS_CTRL);
    check("ninth bit one", rv, 8'h0B);
    check("irq unmasked", irq, 1'b1);
    reg_wr(`SPSA_OFS_MASK, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    check("irq masked", irq, 1'b0);
    reg_wr(`SPSA_OFS_MASK, 8'h02);
    reg_wr(`SPSA_OFS_STAT, 8'h02);
    repeat (2) @(posedge clk);
    #1;
    check("irq cleared", irq, 1'b0);
    reg_rd(`SPSA_OFS_STAT);
    check("flag cleared", rv, 8'h00);
    partner.send_frame(8'h81, 1'b0, 64);
    wait_flag(`SPSA_ST_RX);
    reg_rd(`SPSA_OFS_BUF);
    check("async rx lsb msb", rv, 8'h81);
    reg_rd(`SPSA_OFS_CTRL);
    check("ninth bit zero", rv, 8'h03);
    partner.send_frame(8'h42, 1'b1, 64);
    repeat (20) @(posedge clk);
    reg_rd(`SPSA_OFS_BUF);
    check("overrun dropped", rv, 8'h81);
    reg_rd(`SPSA_OFS_CTRL);
    check("overrun ninth kept", rv, 8'h03);
    final_report();
  end
endmodule
